// ---- itb_pkg.sv ----
// Shared constants for the interrupt sources and time base block
package itb_pkg;
	localparam logic [7:0] ITB_OFS_PSC  = 8'h00;
	localparam logic [7:0] ITB_OFS_TB0  = 8'h04;
	localparam logic [7:0] ITB_OFS_TB1  = 8'h08;
	localparam logic [7:0] ITB_OFS_CTRL = 8'h0C;
	localparam logic [7:0] ITB_OFS_FLAG = 8'h10;
	localparam logic [7:0] ITB_OFS_STAT = 8'h14;
	localparam int ITB_NFLAG = 11;
	localparam int ITB_NCTRL = 12;
	localparam int F_GRP0 = 0;
	localparam int F_GRP1 = 1;
	localparam int F_T0A  = 2;
	localparam int F_T0P  = 3;
	localparam int F_T1A  = 4;
	localparam int F_T1P  = 5;
	localparam int F_EE   = 6;
	localparam int F_TB0  = 7;
	localparam int F_TB1  = 8;
	localparam int F_SIM  = 9;
	localparam int F_CMP  = 10;
	localparam int C_GIE  = 0;
	localparam int C_GE0  = 1;
	localparam int C_GE1  = 2;
	localparam int C_T0A  = 3;
	localparam int C_T0P  = 4;
	localparam int C_T1A  = 5;
	localparam int C_T1P  = 6;
	localparam int C_EE   = 7;
	localparam int C_TB0  = 8;
	localparam int C_TB1  = 9;
	localparam int C_SIM  = 10;
	localparam int C_CMP  = 11;
	localparam int TB_RUN = 7;
	localparam logic [7:0] PSC_MASK = 8'h03;
	localparam logic [7:0] TB_MASK  = 8'h87;
	localparam logic [1:0] PSC_SYS  = 2'h0;
	localparam logic [1:0] PSC_DIV4 = 2'h1;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [15:0] TB_BASE = 16'h0100;
	localparam logic [3:0] STACK_DEPTH = 4'h8;
	localparam logic [7:0] PSC_RST = 8'h00;
	localparam logic [7:0] TB_RST = 8'h00;
	localparam logic [ITB_NCTRL-1:0] CTRL_RST = 12'h000;
	localparam logic [ITB_NFLAG-1:0] FLAG_RST = 11'h000;
	typedef enum logic [2:0] {
		VEC_GRP0, VEC_GRP1, VEC_TB0, VEC_TB1, VEC_SIM, VEC_CMP, VEC_NONE
	} itb_vec_t;
endpackage

// ---- itb_irq_ctrl.sv ----
// Interrupt request flags, time bases, vectoring and wake-up logic
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module itb_irq_ctrl
	import itb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic [1:0]  tm_match_a_i,
	input  wire logic [1:0]  tm_match_p_i,
	input  wire logic        ee_done_i,
	input  wire logic        sim_xfer_i,
	input  wire logic        sim_addr_match_i,
	input  wire logic        sim_timeout_i,
	input  wire logic        cmp_out_i,
	input  wire logic        sub_tick_i,
	input  wire logic        cpu_boundary_i,
	input  wire logic        call_i,
	input  wire logic        ret_i,
	input  wire logic        return_with_irq_enable_i,
	input  wire logic        sleep_i,
	output logic             irq_req_o,
	output logic             irq_enter_o,
	output logic      [2:0]  irq_vector_o,
	output logic             push_pc_o,
	output logic      [3:0]  stack_level_o,
	output logic             wake_o
);

	function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (new_w & m) | (old_w & ~m);
	endfunction

	// Overflow when the low (8 + code) counter bits are all ones
	function automatic logic period_hit(input logic [14:0] cnt,
		input logic [2:0] code);
		logic [14:0] mask;
		mask = 15'((TB_BASE << code) - 16'h0001);
		return (cnt & mask) == mask;
	endfunction

	logic [7:0]           psc_reg;
	logic [7:0]           tb0_reg;
	logic [7:0]           tb1_reg;
	logic [ITB_NCTRL-1:0] ctrl_reg;
	logic [ITB_NCTRL-1:0] ctrl_next;
	logic [ITB_NFLAG-1:0] flag_reg;
	logic [ITB_NFLAG-1:0] flag_next;
	logic [ITB_NFLAG-1:0] flag_prev_reg;
	logic [1:0]           div_cnt_reg;
	logic [14:0]          tb0_cnt_reg;
	logic [14:0]          tb1_cnt_reg;
	logic                 cmp_prev_reg;
	logic [3:0]           level_reg;
	logic [3:0]           level_next;

	wire logic        bus_req  = cyc_i && stb_i && !ack_o;
	wire logic        bus_wr   = bus_req && we_i;
	wire logic        wr_psc   = bus_wr && adr_i == ITB_OFS_PSC;
	wire logic        wr_tb0   = bus_wr && adr_i == ITB_OFS_TB0;
	wire logic        wr_tb1   = bus_wr && adr_i == ITB_OFS_TB1;
	wire logic        wr_ctrl  = bus_wr && adr_i == ITB_OFS_CTRL;
	wire logic        wr_flag  = bus_wr && adr_i == ITB_OFS_FLAG;
	wire logic [31:0] psc_wide = {24'h00_0000, psc_reg};
	wire logic [31:0] tb0_wide = {24'h00_0000, tb0_reg};
	wire logic [31:0] tb1_wide = {24'h00_0000, tb1_reg};
	wire logic [31:0] ctrl_wide = {20'h0_0000, ctrl_reg};
	wire logic [31:0] flag_wide = {21'h00_0000, flag_reg};
	wire logic [31:0] ctrl_wr_w = lane_merge(ctrl_wide, dat_i, sel_i);
	wire logic [31:0] flag_wr_w = lane_merge(flag_wide, dat_i, sel_i);
	wire logic [31:0] psc_wr_w = lane_merge(psc_wide, dat_i, sel_i);
	wire logic [31:0] tb0_wr_w = lane_merge(tb0_wide, dat_i, sel_i);
	wire logic [31:0] tb1_wr_w = lane_merge(tb1_wide, dat_i, sel_i);

	// Prescaler clock as a one-cycle enable
	wire logic [1:0] psc_src  = psc_reg[1:0];
	wire logic       div4_hit = div_cnt_reg == DIV4_LAST;
	wire logic       psc_tick = (psc_src == PSC_SYS) ? 1'b1 :
		(psc_src == PSC_DIV4) ? div4_hit : sub_tick_i;
	wire logic       tb0_run  = tb0_reg[TB_RUN];
	wire logic       tb1_run  = tb1_reg[TB_RUN];
	wire logic       tb0_ovf  = tb0_run && psc_tick &&
		period_hit(tb0_cnt_reg, tb0_reg[2:0]);
	wire logic       tb1_ovf  = tb1_run && psc_tick &&
		period_hit(tb1_cnt_reg, tb1_reg[2:0]);

	// Source events; source flags record them whatever the enables say, group flags only enabled sources
	wire logic ev_t0a = tm_match_a_i[0];
	wire logic ev_t0p = tm_match_p_i[0];
	wire logic ev_t1a = tm_match_a_i[1];
	wire logic ev_t1p = tm_match_p_i[1];
	wire logic ev_sim = sim_xfer_i || sim_addr_match_i ||
		sim_timeout_i;
	wire logic ev_cmp = cmp_out_i ^ cmp_prev_reg;
	wire logic ev_grp0 = (ev_t0a && ctrl_reg[C_T0A]) ||
		(ev_t0p && ctrl_reg[C_T0P]);
	wire logic ev_grp1 = (ev_t1a && ctrl_reg[C_T1A]) ||
		(ev_t1p && ctrl_reg[C_T1P]) || (ee_done_i && ctrl_reg[C_EE]);
	wire logic [ITB_NFLAG-1:0] ev_vec = {ev_cmp, ev_sim, tb1_ovf,
		tb0_ovf, ee_done_i, ev_t1p, ev_t1a, ev_t0p, ev_t0a,
		ev_grp1, ev_grp0};

	// Vector requests
	wire logic gie        = ctrl_reg[C_GIE];
	wire logic stack_full = level_reg == STACK_DEPTH;
	wire logic src0_on = (flag_reg[F_T0A] && ctrl_reg[C_T0A]) ||
		(flag_reg[F_T0P] && ctrl_reg[C_T0P]);
	wire logic src1_on = (flag_reg[F_T1A] && ctrl_reg[C_T1A]) ||
		(flag_reg[F_T1P] && ctrl_reg[C_T1P]) ||
		(flag_reg[F_EE] && ctrl_reg[C_EE]);
	wire logic rq_grp0 = flag_reg[F_GRP0] && ctrl_reg[C_GE0] && src0_on;
	wire logic rq_grp1 = flag_reg[F_GRP1] && ctrl_reg[C_GE1] && src1_on;
	wire logic rq_tb0  = flag_reg[F_TB0] && ctrl_reg[C_TB0];
	wire logic rq_tb1  = flag_reg[F_TB1] && ctrl_reg[C_TB1];
	wire logic rq_sim  = flag_reg[F_SIM] && ctrl_reg[C_SIM];
	wire logic rq_cmp  = flag_reg[F_CMP] && ctrl_reg[C_CMP];
	wire logic rq_any  = rq_grp0 || rq_grp1 || rq_tb0 || rq_tb1 ||
		rq_sim || rq_cmp;
	wire logic irq_ok  = gie && !stack_full && rq_any;
	wire logic enter_w = irq_ok && cpu_boundary_i;

	// Fixed order: groups, time bases, serial, comparator
	wire itb_vec_t vec_sel = rq_grp0 ? VEC_GRP0 :
		rq_grp1 ? VEC_GRP1 :
		rq_tb0 ? VEC_TB0 :
		rq_tb1 ? VEC_TB1 :
		rq_sim ? VEC_SIM :
		rq_cmp ? VEC_CMP : VEC_NONE;

	// Service clears only group, time base, serial, comparator flags
	logic [ITB_NFLAG-1:0] svc_clr;
	always_comb begin
		svc_clr = '0;
		if (enter_w) begin
			case (vec_sel)
				VEC_GRP0: svc_clr[F_GRP0] = 1'b1;
				VEC_GRP1: svc_clr[F_GRP1] = 1'b1;
				VEC_TB0:  svc_clr[F_TB0] = 1'b1;
				VEC_TB1:  svc_clr[F_TB1] = 1'b1;
				VEC_SIM:  svc_clr[F_SIM] = 1'b1;
				VEC_CMP:  svc_clr[F_CMP] = 1'b1;
				default:  svc_clr = '0;
			endcase
		end
	end

	// Set wins over any clear in the same cycle
	wire logic [ITB_NFLAG-1:0] flag_kept = wr_flag ?
		flag_wr_w[ITB_NFLAG-1:0] : flag_reg;
	assign flag_next = (flag_kept & ~svc_clr) | ev_vec;

	always_comb begin
		ctrl_next = wr_ctrl ? ctrl_wr_w[ITB_NCTRL-1:0] : ctrl_reg;
		if (enter_w) begin
			ctrl_next[C_GIE] = 1'b0;
		end else if (return_with_irq_enable_i) begin
			ctrl_next[C_GIE] = 1'b1;
		end
	end

	// Calls beyond the last level are dropped, not wrapped
	wire logic push_w = (enter_w || call_i) && !stack_full;
	wire logic pop_w  = (ret_i || return_with_irq_enable_i) &&
		level_reg != 4'h0;
	assign level_next = push_w && !pop_w ? level_reg + 4'h1 :
		pop_w && !push_w ? level_reg - 4'h1 : level_reg;

	wire logic [ITB_NFLAG-1:0] flag_rise = flag_reg & ~flag_prev_reg;
	wire logic [31:0] rd_word =
		adr_i == ITB_OFS_PSC  ? (psc_wide & {24'h00_0000, PSC_MASK}) :
		adr_i == ITB_OFS_TB0  ? (tb0_wide & {24'h00_0000, TB_MASK}) :
		adr_i == ITB_OFS_TB1  ? (tb1_wide & {24'h00_0000, TB_MASK}) :
		adr_i == ITB_OFS_CTRL ? ctrl_wide :
		adr_i == ITB_OFS_FLAG ? flag_wide :
		adr_i == ITB_OFS_STAT ? {26'h000_0000, irq_ok, stack_full,
			level_reg} : 32'h0000_0000;

	assign irq_req_o     = irq_ok;
	assign stack_level_o = level_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req;
			dat_o <= bus_req ? rd_word : dat_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			psc_reg <= PSC_RST;
			tb0_reg <= TB_RST;
			tb1_reg <= TB_RST;
		end else begin
			if (wr_psc) psc_reg <= psc_wr_w[7:0] & PSC_MASK;
			if (wr_tb0) tb0_reg <= tb0_wr_w[7:0] & TB_MASK;
			if (wr_tb1) tb1_reg <= tb1_wr_w[7:0] & TB_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg      <= CTRL_RST;
			flag_reg      <= FLAG_RST;
			flag_prev_reg <= FLAG_RST;
			level_reg     <= 4'h0;
			cmp_prev_reg  <= 1'b0;
		end else begin
			ctrl_reg      <= ctrl_next;
			flag_reg      <= flag_next;
			flag_prev_reg <= flag_reg;
			level_reg     <= level_next;
			cmp_prev_reg  <= cmp_out_i;
		end
	end

	// Stopped time bases restart from zero for a full first period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_reg <= 2'h0;
			tb0_cnt_reg <= 15'h0000;
			tb1_cnt_reg <= 15'h0000;
		end else begin
			div_cnt_reg <= div_cnt_reg + 2'h1;
			if (!tb0_run) tb0_cnt_reg <= 15'h0000;
			else if (psc_tick) tb0_cnt_reg <= tb0_cnt_reg + 15'h0001;
			if (!tb1_run) tb1_cnt_reg <= 15'h0000;
			else if (psc_tick) tb1_cnt_reg <= tb1_cnt_reg + 15'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_enter_o  <= 1'b0;
			push_pc_o    <= 1'b0;
			irq_vector_o <= 3'(VEC_NONE);
			wake_o       <= 1'b0;
		end else begin
			irq_enter_o <= enter_w;
			push_pc_o   <= enter_w;
			if (enter_w) irq_vector_o <= 3'(vec_sel);
			wake_o <= sleep_i && |flag_rise;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_div_quiet;
		(!psc_tick || psc_src != PSC_DIV4) [*3];
	endsequence

	property p_ack_drop;
		ack_o |=> !ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop)
		else $error("ack held longer than one cycle");

	property p_entry_cond;
		irq_enter_o |-> $past(gie) && !$past(stack_full);
	endproperty
	a_entry_cond: assert property (p_entry_cond)
		else $error("entry without global enable or with full stack");

	property p_full_blocks;
		stack_full |-> !irq_req_o;
	endproperty
	a_full_blocks: assert property (p_full_blocks)
		else $error("request raised while stack full");

	property p_entry_gie;
		irq_enter_o |-> !gie && push_pc_o &&
			level_reg == $past(level_reg) + 4'h1;
	endproperty
	a_entry_gie: assert property (p_entry_gie)
		else $error("entry did not push or clear global enable");

	property p_grp_src_kept;
		irq_enter_o && irq_vector_o == 3'(VEC_GRP0) &&
			$past(flag_reg[F_T0A]) |-> flag_reg[F_T0A];
	endproperty
	a_grp_src_kept: assert property (p_grp_src_kept)
		else $error("timer source flag cleared by service");

	property p_ee_kept;
		irq_enter_o && irq_vector_o == 3'(VEC_GRP1) &&
			$past(flag_reg[F_EE]) |-> flag_reg[F_EE];
	endproperty
	a_ee_kept: assert property (p_ee_kept)
		else $error("eeprom flag cleared by service");

	property p_tb0_period;
		tb0_ovf && tb0_reg[2:0] == 3'h0 |-> tb0_cnt_reg[7:0] == 8'hFF
			##1 flag_reg[F_TB0];
	endproperty
	a_tb0_period: assert property (p_tb0_period)
		else $error("first time base overflow at wrong count");

	property p_div4;
		psc_src == PSC_DIV4 && psc_tick ##1 psc_src == PSC_DIV4
			|-> s_div_quiet;
	endproperty
	a_div4: assert property (p_div4)
		else $error("divided prescaler ticked too often");

	property p_wake;
		sleep_i && |flag_rise |=> wake_o;
	endproperty
	a_wake: assert property (p_wake)
		else $error("rising flag did not wake");

	property p_cmp_set;
		ev_cmp |=> flag_reg[F_CMP];
	endproperty
	a_cmp_set: assert property (p_cmp_set)
		else $error("comparator transition lost");

	property p_hold;
		flag_reg[F_SIM] && !wr_flag && !svc_clr[F_SIM] |=>
			flag_reg[F_SIM];
	endproperty
	a_hold: assert property (p_hold)
		else $error("serial flag dropped on its own");

	property p_return_with_irq_enable;
		return_with_irq_enable_i && !enter_w |=> gie;
	endproperty
	a_return_with_irq_enable: assert property (p_return_with_irq_enable)
		else $error("interrupt return did not set global enable");

	property p_ret;
		ret_i && !gie && !wr_ctrl && !return_with_irq_enable_i |=> !gie;
	endproperty
	a_ret: assert property (p_ret)
		else $error("plain return changed global enable");

endmodule // itb_irq_ctrl

// ---- itb_cpu_model.sv ----
// Behavioural CPU sequencer with a program counter stack
`timescale 1ns/1ps
module itb_cpu_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       take_en_i,
	input  wire logic       irq_enter_i,
	input  wire logic       push_pc_i,
	input  wire logic       call_req_i,
	input  wire logic       ret_req_i,
	input  wire logic       return_with_irq_enable_req_i,
	output logic            cpu_boundary_o,
	output logic            call_o,
	output logic            ret_o,
	output logic            return_with_irq_enable_o,
	output logic      [3:0] pc_depth_o
);
	logic in_svc_reg;
	// Calls inside a service routine could overrun a nearly full stack
	wire call_ok = call_req_i & ~in_svc_reg & (pc_depth_o != 4'h8);
	assign cpu_boundary_o = take_en_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{in_svc_reg, call_o, ret_o, return_with_irq_enable_o} <= 4'h0;
			pc_depth_o <= 4'h0;
		end else begin
			call_o <= call_ok;
			ret_o <= ret_req_i;
			return_with_irq_enable_o <= return_with_irq_enable_req_i;
			if (irq_enter_i)
				in_svc_reg <= 1'b1;
			else if (ret_o | return_with_irq_enable_o)
				in_svc_reg <= 1'b0;
			// Entry saves the program counter and nothing else
			if (push_pc_i | call_o)
				pc_depth_o <= pc_depth_o + 4'h1;
			else if ((ret_o | return_with_irq_enable_o) && pc_depth_o != 4'h0)
				pc_depth_o <= pc_depth_o - 4'h1;
		end
	end
endmodule // itb_cpu_model

// ---- test_irq_sources_and_time_base.sv ----
// Self-checking bench for the interrupt sources and time base block
`timescale 1ns/1ps
`define CHK(g, e) cmp(32'(g), 32'(e))
module test_irq_sources_and_time_base
	import itb_pkg::*;
;
	logic        clk_i = 1'b0, sub_tick_i = 1'b0;
	logic        rst_i, cyc_i, stb_i, we_i, sleep_i, cmp_out_i;
	logic        take_en, call_req, ret_req, return_with_irq_enable_req;
	logic [7:0]  adr_i, evt;
	logic [31:0] dat_i, rdv, t1;
	logic [3:0]  sel_i;
	wire  [31:0] dat_o;
	wire         ack_o, irq_req_o, irq_enter_o, push_pc_o, wake_o;
	wire         cpu_boundary_i, call_i, ret_i, return_with_irq_enable_i;
	wire  [2:0]  irq_vector_o;
	wire  [3:0]  stack_level_o, pc_depth;
	int          fail_count = 0, num_checks = 0, cyc_cnt = 0, i;
	int          fb[5] = '{F_T0A, F_T1A, F_T0P, F_T1P, F_EE};
	int          tp[5] = '{0, 1, 2, 3, 0}, tc[5] = '{0, 1, 0, 0, 6};
	int          tx[5] = '{256, 2048, 2048, 2048, 16384};
	logic [7:0]  tr[5] = '{ITB_OFS_TB0, ITB_OFS_TB0, ITB_OFS_TB0,
		ITB_OFS_TB1, ITB_OFS_TB1};
	logic [7:0]  ro[3] = '{ITB_OFS_PSC, ITB_OFS_TB0, ITB_OFS_TB1};
	logic [31:0] rm[3] = '{32'h0000_0003, 32'h0000_0087, 32'h0000_0087};

	itb_irq_ctrl dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .tm_match_a_i(evt[1:0]),
		.tm_match_p_i(evt[3:2]), .ee_done_i(evt[4]), .sim_xfer_i(evt[5]),
		.sim_addr_match_i(evt[6]), .sim_timeout_i(evt[7]), .cmp_out_i,
		.sub_tick_i, .cpu_boundary_i, .call_i, .ret_i, .sleep_i,
		.return_with_irq_enable_i, .irq_req_o, .irq_enter_o, .irq_vector_o,
		.push_pc_o, .stack_level_o, .wake_o);
	itb_cpu_model cpu_u (.clk_i, .rst_i, .take_en_i(take_en),
		.irq_enter_i(irq_enter_o), .push_pc_i(push_pc_o),
		.call_req_i(call_req), .ret_req_i(ret_req), .return_with_irq_enable_req_i(return_with_irq_enable_req),
		.cpu_boundary_o(cpu_boundary_i), .call_o(call_i), .ret_o(ret_i),
		.return_with_irq_enable_o(return_with_irq_enable_i), .pc_depth_o(pc_depth));

	always #2.5 clk_i = ~clk_i;
	// Sub clock ticks once every eight system cycles
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		sub_tick_i <= (cyc_cnt[2:0] == 3'h6);
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic timeout;
		fail_count++;
		$display("unexpected at %0t: wait ran out", $time);
		summarize();
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rdv = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		if (n >= 20) timeout();
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(rdv, e);
	endtask
	// Kind 0 waits for a request, kind 1 for an entry
	task automatic await(input int s, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!(s == 0 ? irq_req_o === 1'b1 : irq_enter_o === 1'b1)
			&& n < lim);
		if (n >= lim) timeout();
	endtask
	task automatic ent(input itb_vec_t v);
		await(1, 300);
		`CHK(irq_vector_o, v);
		`CHK(push_pc_o, 1'b1);
	endtask
	task automatic fire(input logic [7:0] m);
		@(posedge clk_i) evt <= m;
		@(posedge clk_i) evt <= 8'h00;
	endtask
	task automatic cpu(input logic [2:0] m);
		@(posedge clk_i) {call_req, ret_req, return_with_irq_enable_req} <= m;
		@(posedge clk_i) {call_req, ret_req, return_with_irq_enable_req} <= 3'h0;
	endtask
	task automatic wk(input logic e);
		logic w;
		w = 1'b0;
		repeat (4) @(posedge clk_i) if (wake_o === 1'b1) w = 1'b1;
		`CHK(w, e);
	endtask
	task automatic toggle;
		@(posedge clk_i) cmp_out_i <= ~cmp_out_i;
	endtask

	initial begin
		{rst_i, cyc_i, stb_i, we_i, sleep_i, cmp_out_i} = 6'h20;
		{take_en, call_req, ret_req, return_with_irq_enable_req, evt, adr_i} = '0;
		{dat_i, sel_i} = {32'h0000_0000, 4'hf};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i <= 24; i += 4) rc(8'(i), 32'h0000_0000);
		for (i = 0; i < 3; i++) begin
			bus(1'b1, ro[i], 32'hffff_ffff);
			rc(ro[i], rm[i]);
			bus(1'b1, ro[i], 32'h0000_0000);
		end
		bus(1'b1, 8'h18, 32'hffff_ffff);
		rc(8'h18, 32'h0000_0000);
		$display("test registers done");
		take_en <= 1'b1;
		for (i = 0; i < 5; i++) begin
			bus(1'b1, ITB_OFS_CTRL, 32'h0000_00ff);
			fire(8'(1 << i));
			ent((i % 2 == 0 && i < 4) ? VEC_GRP0 : VEC_GRP1);
			rc(ITB_OFS_FLAG, 32'(1) << fb[i]);
			rc(ITB_OFS_CTRL, 32'h0000_00fe);
			rc(ITB_OFS_STAT, 32'h0000_0001);
			bus(1'b1, ITB_OFS_FLAG, 32'h0000_0000);
			cpu(3'h1);
			rc(ITB_OFS_CTRL, 32'h0000_00ff);
		end
		$display("test groups done");
		for (i = 5; i < 8; i++) begin
			bus(1'b1, ITB_OFS_CTRL, 32'h0000_0c00);
			fire(8'(1 << i));
			toggle();
			rc(ITB_OFS_FLAG, 32'h0000_0600);
			bus(1'b1, ITB_OFS_CTRL, 32'h0000_0c01);
			ent(VEC_SIM);
			rc(ITB_OFS_FLAG, 32'h0000_0400);
			cpu(3'h1);
			ent(VEC_CMP);
			rc(ITB_OFS_FLAG, 32'h0000_0000);
			cpu(3'h1);
		end
		$display("test serial done");
		// Periods are measured between two requests with service held off
		take_en <= 1'b0;
		bus(1'b1, ITB_OFS_CTRL, 32'h0000_0301);
		for (i = 0; i < 5; i++) begin
			bus(1'b1, ITB_OFS_PSC, 32'(tp[i]));
			bus(1'b1, tr[i], 32'h0000_0080 | 32'(tc[i]));
			await(0, 40000);
			t1 = cyc_cnt;
			bus(1'b1, ITB_OFS_FLAG, 32'h0000_0000);
			await(0, 40000);
			`CHK(cyc_cnt - t1, tx[i]);
			bus(1'b1, tr[i], 32'h0000_0000);
			bus(1'b1, ITB_OFS_FLAG, 32'h0000_0000);
		end
		take_en <= 1'b1;
		bus(1'b1, ITB_OFS_TB0, 32'h0000_0080);
		ent(VEC_TB0);
		bus(1'b1, ITB_OFS_TB0, 32'h0000_0000);
		rc(ITB_OFS_FLAG, 32'h0000_0000);
		cpu(3'h1);
		$display("test time base done");
		for (i = 0; i < 8; i++) cpu(3'h4);
		bus(1'b1, ITB_OFS_CTRL, 32'h0000_0401);
		fire(8'h20);
		rc(ITB_OFS_STAT, 32'h0000_0018);
		cpu(3'h2);
		ent(VEC_SIM);
		rc(ITB_OFS_STAT, 32'h0000_0018);
		cpu(3'h2);
		rc(ITB_OFS_CTRL, 32'h0000_0400);
		for (i = 0; i < 7; i++) cpu(3'h2);
		rc(ITB_OFS_STAT, 32'h0000_0000);
		`CHK(pc_depth, stack_level_o);
		$display("test stack done");
		bus(1'b1, ITB_OFS_CTRL, 32'h0000_0000);
		// Serial flag preset by software so its event cannot wake
		bus(1'b1, ITB_OFS_FLAG, 32'h0000_0200);
		sleep_i <= 1'b1;
		fire(8'h80);
		wk(1'b0);
		fire(8'h01);
		wk(1'b1);
		toggle();
		wk(1'b1);
		sleep_i <= 1'b0;
		$display("test wake done");
		summarize();
	end
endmodule // test_irq_sources_and_time_base
